// ==== rtl/ers_node.sv ====
// error record node: records component reports, exposes via axi4-lite
// assumes reports are synchronous to clk and one report per cycle at most
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// - corrected type: transient, persistent or unjudged
// - overwrite poison only for propagated deferred errors
// - self-deferred poison logs deferred, poison clear
// - ambiguous stored poison logs plain uncorrectable
// - msi writes never target secure addresses
// - secure-data node: secure-only or reduced view
// - non-secure node visibility chosen by parameter
// - non-secure sysreg view reduced, hides secure data
// - report updates record, may raise interrupts
// - reads after interrupt see updated record
// - record update completes in bounded time
// - selected-record access counts as select read; here only sysreg access does, OFF_SEL_STATUS reads over axi do not
// - bridge logs errored crossings with source, direction
// - pcie-domain errors not logged here
// - each one-way transfer counts as one transaction
// - kept syndrome leaves poison, fields, address alone
// - any new syndrome sets record valid
module ers_node #(
   parameter bit SECURE_DATA = 1'b1,
   parameter logic [1:0] NS_VIS_MODE = 2'h1, // 0 both, 1 configurable, 2 secure only
   parameter logic [63:0] SECURE_MSI_BASE = 64'h0000_0000_8000_0000,
   parameter logic [63:0] SECURE_MSI_TOP = 64'h0000_0000_8fff_ffff
) (
   input wire logic clk,
   input wire logic rst_n,
   input ers_pkg::ers_report_s report,
   input ers_pkg::ers_xfer_s xfer,
   input wire logic sys_access,
   input wire logic sys_secure,
   output logic sys_select_read,
   output logic [31:0] sys_rdata,
   input wire logic [63:0] msi_target,
   input wire logic msi_req,
   output logic msi_fire,
   output logic inband_err,
   output logic fault_irq,
   output logic recovery_irq,
   output logic critical_irq,
   output logic irq,
   input wire logic [7:0] s_awaddr,
   input wire logic [2:0] s_awprot,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic [2:0] s_arprot,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);
   import ers_pkg::*;

   logic [31:0] status;
   logic [63:0] addr;
   logic [31:0] ctrl;
   logic [31:0] select;
   logic [4:0] irq_stat;
   logic [4:0] irq_mask;
   logic [31:0] bridge_log;
   logic [4:0] irq_set;
   logic [4:0] irq_clr;
   logic rec_en;
   logic new_pn;
   logic ns_ok_w;
   logic ns_ok_r;
   logic aw_hold;
   logic w_hold;
   logic [7:0] aw_addr;
   logic aw_prot1;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic [31:0] next_rdata;
   logic next_rok;
   logic bridge_hit;

   // pcie-domain errors belong to that domain's own logs
   assign rec_en = report.valid && !report.pcie_domain;

   // poison only when a propagated deferred error is logged ue or re-deferred
   always_comb begin
      new_pn = 1'b0;
      if (report.saw_poison && !report.poison_ambig && !report.emits_poison) begin
         new_pn = (report.sev == ERS_SEV_UE) ||
                  (report.sev == ERS_SEV_DE && report.redeferred);
      end
   end

   // record status and address; single-cycle update keeps reads coherent
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= 32'h0000_0000;
         addr <= 64'h0000_0000_0000_0000;
      end else if (rec_en) begin
         if (!report.keep || !status[ST_V]) begin
            status[ST_V] <= 1'b1;
            status[ST_UE] <= (report.sev == ERS_SEV_UE);
            status[ST_DE] <= (report.sev == ERS_SEV_DE) || report.emits_poison;
            status[ST_PN] <= new_pn;
            status[ST_CE_LO +: 2] <= (report.sev == ERS_SEV_CE) ?
               ((report.ce_kind == CE_NONE) ? CE_UNJUDGED : report.ce_kind) : CE_NONE;
            status[ST_SERR_LO +: 8] <= report.serr;
            status[ST_AV] <= report.addr_valid;
            if (report.addr_valid) begin
               addr <= report.addr;
            end
         end else begin
            // kept: only the severity summary bits accumulate
            if (report.sev == ERS_SEV_UE) begin
               status[ST_UE] <= 1'b1;
            end
            if (report.sev == ERS_SEV_DE) begin
               status[ST_DE] <= 1'b1;
            end
         end
      end else if (do_write && aw_addr == OFF_STATUS && (!aw_prot1 || ns_ok_w)) begin
         // write one to clear the top status byte: valid, summary and ce type bits
         if (w_strb[3]) begin
            status[31:24] <= status[31:24] & ~w_data[31:24];
         end
      end
   end

   // bridge log: every one-way transfer is checked on its own
   assign bridge_hit = xfer.valid && xfer.err;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bridge_log <= 32'h0000_0000;
      end else if (bridge_hit) begin
         bridge_log <= {1'b1, 14'h0000, xfer.inbound, xfer.source, 8'h00};
      end
   end

   // security view: secure-data nodes hide from non-secure unless ctrl allows reduced
   always_comb begin
      if (SECURE_DATA) begin
         ns_ok_r = ctrl[0]; // reduced view only
         ns_ok_w = 1'b0;
      end else begin
         unique case (NS_VIS_MODE)
            2'h0: ns_ok_r = 1'b1;
            2'h1: ns_ok_r = ctrl[0];
            default: ns_ok_r = 1'b0;
         endcase
         ns_ok_w = ns_ok_r;
      end
   end

   // sysreg view of the selected record; also an indirect read of select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_select_read <= 1'b0;
         sys_rdata <= 32'h0000_0000;
      end else begin
         sys_select_read <= sys_access;
         if (sys_access && select == 32'h0000_0000) begin
            // non-secure sees summary bits only, no address or syndrome
            sys_rdata <= sys_secure ? status : {status[ST_V], 2'h0, status[ST_DE], 28'h0};
         end else begin
            sys_rdata <= 32'h0000_0000;
         end
      end
   end

   // msi gated away from the secure window
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         msi_fire <= 1'b0;
      end else begin
         msi_fire <= msi_req && !(msi_target >= SECURE_MSI_BASE &&
                                  msi_target <= SECURE_MSI_TOP);
      end
   end

   // event sources, also raised when the syndrome is kept
   always_comb begin
      irq_set = 5'h00;
      irq_set[IRQ_FHI] = rec_en && report.sev == ERS_SEV_CE;
      irq_set[IRQ_ERI] = rec_en && report.sev != ERS_SEV_CE;
      irq_set[IRQ_CRI] = rec_en && report.critical;
      irq_set[IRQ_BRG] = bridge_hit;
      irq_set[IRQ_SEL] = sys_access;
      irq_clr = 5'h00;
      // refused non-secure writes must not clear pending events either
      if (do_write && aw_addr == OFF_IRQ_STAT && w_strb[0] && (!aw_prot1 || ns_ok_w)) begin
         irq_clr = w_data[4:0];
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   // interrupts rise on the same edge as the record write, so reads see it
   assign fault_irq = irq_stat[IRQ_FHI] & irq_mask[IRQ_FHI];
   assign recovery_irq = irq_stat[IRQ_ERI] & irq_mask[IRQ_ERI];
   assign critical_irq = irq_stat[IRQ_CRI] & irq_mask[IRQ_CRI];
   assign irq = |(irq_stat & irq_mask);

   // in-band error pulse for uncorrected reports
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inband_err <= 1'b0;
      end else begin
         inband_err <= rec_en && report.sev == ERS_SEV_UE && ctrl[1];
      end
   end

   // axi write channel capture, either order
   assign s_awready = !aw_hold;
   assign s_wready = !w_hold;
   assign do_write = aw_hold && w_hold && !s_bvalid;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         aw_prot1 <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_awaddr;
            aw_prot1 <= s_awprot[1];
         end
         if (s_wvalid && s_wready) begin
            w_hold <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end
         if (do_write) begin
            s_bvalid <= 1'b1;
            s_bresp <= (aw_prot1 && !ns_ok_w) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
         end
      end
   end

   // control registers, writes from non-secure ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= 32'h0000_0000;
         select <= 32'h0000_0000;
         irq_mask <= IRQ_RESET;
      end else if (do_write && !aw_prot1) begin
         unique case (aw_addr)
            OFF_CTRL: ctrl <= w_data;
            OFF_SELECT: select <= w_data;
            OFF_IRQ_MASK: irq_mask <= w_data[4:0];
            default: ;
         endcase
      end
   end

   // read decode; unmapped reads as zero
   always_comb begin
      next_rok = !s_arprot[1] || ns_ok_r;
      unique case (s_araddr)
         OFF_STATUS: next_rdata = status;
         OFF_ADDR_LO: next_rdata = addr[31:0];
         OFF_ADDR_HI: next_rdata = addr[63:32];
         OFF_CTRL: next_rdata = ctrl;
         OFF_SELECT: next_rdata = select;
         OFF_IRQ_STAT: next_rdata = {27'h0, irq_stat};
         OFF_IRQ_MASK: next_rdata = {27'h0, irq_mask};
         OFF_BRIDGE: next_rdata = bridge_log;
         OFF_SEL_STATUS: next_rdata = (select == 32'h0000_0000) ? status : 32'h0000_0000;
         default: next_rdata = 32'h0000_0000;
      endcase
      // secure-data node: non-secure gets summary bits only, no address or syndrome
      if (SECURE_DATA && s_arprot[1]) begin
         next_rdata = (s_araddr == OFF_STATUS) ?
            {status[ST_V], 2'h0, status[ST_DE], 28'h0} : 32'h0000_0000;
      end
   end

   // read channel: one cycle to answer
   assign s_arready = !s_rvalid;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= next_rok ? next_rdata : 32'h0000_0000;
         s_rresp <= next_rok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rready) begin
         s_rvalid <= 1'b0;
      end
   end

   // checks
   a_valid_on_write: assert property (@(posedge clk) disable iff (!rst_n)
      rec_en && (!report.keep || !status[ST_V]) |=> status[ST_V])
      else $error("record valid not set");
   a_kept_poison: assert property (@(posedge clk) disable iff (!rst_n)
      rec_en && report.keep && status[ST_V] |=> $stable(status[ST_PN]) &&
      $stable(status[ST_AV]) && $stable(status[7:0]) && $stable(addr))
      else $error("kept syndrome changed");
   a_pn_self_defer: assert property (@(posedge clk) disable iff (!rst_n)
      rec_en && report.emits_poison && !report.keep |=> !status[ST_PN])
      else $error("self-deferred poison flagged");
   a_pn_ambig: assert property (@(posedge clk) disable iff (!rst_n)
      rec_en && report.poison_ambig && !report.keep |=> !status[ST_PN])
      else $error("ambiguous poison flagged");
   a_pn_prop: assert property (@(posedge clk) disable iff (!rst_n)
      rec_en && !report.keep && report.saw_poison && report.sev == ERS_SEV_UE &&
      !report.poison_ambig && !report.emits_poison |=> status[ST_PN])
      else $error("propagated poison missed");
   a_msi_secure: assert property (@(posedge clk) disable iff (!rst_n)
      msi_req && msi_target >= SECURE_MSI_BASE && msi_target <= SECURE_MSI_TOP
      |=> !msi_fire)
      else $error("msi to secure address");
   a_select_read: assert property (@(posedge clk) disable iff (!rst_n)
      sys_access |=> sys_select_read)
      else $error("select read missing");
   a_pcie_skip: assert property (@(posedge clk) disable iff (!rst_n)
      report.valid && report.pcie_domain && !(do_write && aw_addr == OFF_STATUS)
      |=> $stable(status))
      else $error("pcie error logged");
   a_bridge_log: assert property (@(posedge clk) disable iff (!rst_n)
      bridge_hit |=> bridge_log[31] && bridge_log[16] == $past(xfer.inbound))
      else $error("crossing not logged");
   a_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
      rec_en && report.sev == ERS_SEV_UE && irq_mask[IRQ_ERI] && !irq_clr[IRQ_ERI]
      |=> status[ST_UE] && recovery_irq)
      else $error("irq before record update");
endmodule

// ==== rtl/ers_pkg.sv ====
// package for the error record syndrome node: offsets, fields, types
// assumes a single clock domain and an axi4-lite register port
package ers_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_ADDR_LO = 8'h04;
   localparam logic [7:0] OFF_ADDR_HI = 8'h08;
   localparam logic [7:0] OFF_CTRL = 8'h0c;
   localparam logic [7:0] OFF_SELECT = 8'h10;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFF_BRIDGE = 8'h1c;
   localparam logic [7:0] OFF_SEL_STATUS = 8'h20;
   // status field positions
   localparam int ST_V = 31;
   localparam int ST_AV = 30;
   localparam int ST_UE = 29;
   localparam int ST_DE = 28;
   localparam int ST_PN = 27;
   localparam int ST_CE_LO = 24;
   localparam int ST_SERR_LO = 0;
   // corrected error type encodings
   localparam logic [1:0] CE_NONE = 2'h0;
   localparam logic [1:0] CE_TRANSIENT = 2'h1;
   localparam logic [1:0] CE_PERSIST = 2'h2;
   localparam logic [1:0] CE_UNJUDGED = 2'h3;
   // irq bits
   localparam int IRQ_FHI = 0;
   localparam int IRQ_ERI = 1;
   localparam int IRQ_CRI = 2;
   localparam int IRQ_BRG = 3;
   localparam int IRQ_SEL = 4;
   localparam logic [4:0] IRQ_RESET = 5'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // severity of a report
   typedef enum logic [1:0] {
      ERS_SEV_CE = 2'h0,
      ERS_SEV_DE = 2'h1,
      ERS_SEV_UE = 2'h2
   } ers_sev_e;
   // one error report from a component
   typedef struct packed {
      logic valid;
      ers_sev_e sev;
      logic [1:0] ce_kind;   // transient, persistent or unjudged
      logic saw_poison;      // checked value was already poisoned
      logic redeferred;      // component deferred it again
      logic emits_poison;    // component deferred by making poison
      logic poison_ambig;    // edc cannot tell poison from corruption
      logic keep;            // priority logic says keep old syndrome
      logic addr_valid;
      logic [63:0] addr;
      logic [7:0] serr;
      logic pcie_domain;     // detected inside the pcie domain
      logic critical;
   } ers_report_s;
   // one bridge crossing with error flag
   typedef struct packed {
      logic valid;
      logic err;
      logic inbound;
      logic [7:0] source;
   } ers_xfer_s;
endpackage

// ==== test/ers_comp_model.sv ====
// component-side model: error reports and bridge crossings toward the node
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module ers_comp_model (
   input wire logic clk,
   output ers_pkg::ers_report_s report,
   output ers_pkg::ers_xfer_s xfer
);
   import ers_pkg::*;
   // idle at time zero
   initial begin
      report = '0;
      xfer = '0;
   end
   // one-cycle report; idle payload inverted so stale fields cannot pass
   task automatic send_rep(input ers_report_s r);
      @(posedge clk);
      report <= r;
      @(posedge clk);
      report <= {1'b0, ~r[$bits(r)-2:0]};
   endtask
   // each crossing is one single one-way transfer
   task automatic send_xfer(input ers_xfer_s x);
      @(posedge clk);
      xfer <= x;
      @(posedge clk);
      xfer <= {1'b0, ~x[$bits(x)-2:0]};
   endtask
endmodule

// ==== test/tb_top.sv ====
// bench for the error record node: axi4-lite tasks plus report sequences
// assumes default parameters: secure-data node, default msi window
`timescale 1ns/1ps
module tb_top;
   import ers_pkg::*;
   logic clk, rst_n, sys_access, sys_secure, sys_select_read, msi_req, msi_fire;
   logic inband_err, fault_irq, recovery_irq, critical_irq, irq;
   logic [31:0] sys_rdata, s_wdata, s_rdata, d;
   logic [63:0] msi_target;
   logic [7:0] s_awaddr, s_araddr;
   logic [2:0] s_awprot, s_arprot;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   ers_report_s report, r;
   ers_xfer_s xfer, x;
   int n_errors, n_tests, i;
   int cyc = 0;
   logic [6:0] t;
   localparam logic [2:0] PS = 3'h0;
   localparam logic [2:0] PNS = 3'h2;
   // sev, saw, redeferred, emits, ambiguous, expected poison bit
   localparam logic [6:0] PNT [5] = '{7'h39, 7'h51, 7'h30, 7'h24, 7'h52};
   ers_node DUT (
      .clk(clk), .rst_n(rst_n), .report(report), .xfer(xfer),
      .sys_access(sys_access), .sys_secure(sys_secure),
      .sys_select_read(sys_select_read), .sys_rdata(sys_rdata),
      .msi_target(msi_target), .msi_req(msi_req), .msi_fire(msi_fire),
      .inband_err(inband_err), .fault_irq(fault_irq), .recovery_irq(recovery_irq),
      .critical_irq(critical_irq), .irq(irq),
      .s_awaddr(s_awaddr), .s_awprot(s_awprot), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arprot(s_arprot), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready)
   );
   ers_comp_model src (.clk(clk), .report(report), .xfer(xfer));
   // free-running clock, 200 MHz
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic test_done();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // address and data offered together, each dropped on its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st,
                     input logic [2:0] p, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge clk);
      s_awaddr <= a;
      s_wdata <= v;
      s_wstrb <= st;
      s_awprot <= p;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (aw && s_awready === 1'b1) begin
            aw = 1'b0;
            s_awvalid <= 1'b0;
         end
         if (w && s_wready === 1'b1) begin
            w = 1'b0;
            s_wvalid <= 1'b0;
         end
      end while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      chk("bresp", 32'(er), 32'(s_bresp));
   endtask
   task automatic rd(input logic [7:0] a, input logic [2:0] p, input logic [1:0] er,
                     output logic [31:0] v);
      logic ar;
      ar = 1'b1;
      @(posedge clk);
      s_araddr <= a;
      s_arprot <= p;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (ar && s_arready === 1'b1) begin
            ar = 1'b0;
            s_arvalid <= 1'b0;
         end
      end while (s_rvalid !== 1'b1);
      v = s_rdata;
      s_rready <= 1'b0;
      chk("rresp", 32'(er), 32'(s_rresp));
   endtask
   // secure read compared under a mask
   task automatic chkr(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m);
      logic [31:0] v;
      rd(a, PS, RESP_OKAY, v);
      chk(nm, e, v & m);
   endtask
   task automatic sysrd(input logic s, input logic [31:0] e);
      @(posedge clk);
      sys_access <= 1'b1;
      sys_secure <= s;
      @(posedge clk);
      sys_access <= 1'b0;
      #1;
      chk("sel_read", 32'h0000_0001, 32'(sys_select_read));
      chk("sys_rdata", e, sys_rdata);
   endtask
   task automatic msi(input logic [63:0] a, input logic e);
      @(posedge clk);
      msi_target <= a;
      msi_req <= 1'b1;
      @(posedge clk);
      msi_req <= 1'b0;
      #1;
      chk("msi_fire", 32'(e), 32'(msi_fire));
   endtask
   function automatic ers_report_s mk(input ers_sev_e s, input logic [7:0] e);
      ers_report_s q;
      q = '0;
      q.valid = 1'b1;
      q.sev = s;
      q.serr = e;
      return q;
   endfunction
   // main sequence
   initial begin
      {sys_access, sys_secure, msi_req, msi_target, n_errors, n_tests} = '0;
      {s_awaddr, s_awprot, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
      {s_araddr, s_arprot, s_arvalid, s_rready} = '0;
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chkr("st_reset", OFF_STATUS, 32'h0000_0000, 32'hffff_ffff);
      for (i = 0; i < 5; i++) begin
         t = PNT[i];
         r = mk(ers_sev_e'(t[6:5]), 8'(i + 8'h40));
         r.saw_poison = t[4];
         r.redeferred = t[3];
         r.emits_poison = t[2];
         r.poison_ambig = t[1];
         r.addr_valid = 1'b1;
         r.addr = 64'(i + 32'h1000);
         src.send_rep(r);
         chkr("st_pn", OFF_STATUS, {4'hc, t[0], 19'h0, r.serr}, 32'hc800_00ff);
         chkr("addr", OFF_ADDR_LO, 32'(i + 32'h1000), 32'hffff_ffff);
      end
      // kept syndrome: poisoned uncorrected report must not leak in
      r = mk(ERS_SEV_UE, 8'hee);
      r.saw_poison = 1'b1;
      r.keep = 1'b1;
      r.addr_valid = 1'b1;
      r.addr = 64'h0000_0000_0000_0055;
      src.send_rep(r);
      chkr("st_keep", OFF_STATUS, 32'hc000_0044, 32'hc800_00ff);
      chkr("addr_keep", OFF_ADDR_LO, 32'h0000_1004, 32'hffff_ffff);
      wr(OFF_STATUS, 32'hff00_0000, 4'h8, PS, RESP_OKAY);
      chkr("st_clear", OFF_STATUS, 32'h0000_0000, 32'h8000_0000);
      for (i = 0; i < 4; i++) begin
         r = mk(ERS_SEV_CE, 8'h00);
         r.ce_kind = 2'(i);
         src.send_rep(r);
         chkr("ce_kind", OFF_STATUS, {1'b1, 5'h0, (i == 0) ? 2'h3 : 2'(i), 24'h0},
              32'h8b00_0000);
      end
      wr(OFF_STATUS, 32'hff00_0000, 4'h8, PS, RESP_OKAY);
      r = mk(ERS_SEV_UE, 8'h01);
      r.pcie_domain = 1'b1;
      src.send_rep(r);
      chkr("st_pcie", OFF_STATUS, 32'h0000_0000, 32'h8000_0000);
      r = mk(ERS_SEV_DE, 8'h3c);
      r.emits_poison = 1'b1;
      r.addr_valid = 1'b1;
      src.send_rep(r);
      sysrd(1'b1, 32'hd000_003c);
      sysrd(1'b0, 32'h9000_0000);
      // security gating on the register port
      rd(OFF_STATUS, PNS, RESP_SLVERR, d);
      chk("ns_rdata", 32'h0000_0000, d);
      wr(OFF_CTRL, 32'h0000_0002, 4'hf, PNS, RESP_SLVERR);
      chkr("ctrl", OFF_CTRL, 32'h0000_0000, 32'h0000_0003);
      wr(OFF_CTRL, 32'h0000_0003, 4'hf, PS, RESP_OKAY);
      rd(OFF_STATUS, PNS, RESP_OKAY, d);
      chk("ns_view", 32'h9000_0000, d);
      chkr("unmapped", 8'h3c, 32'h0000_0000, 32'hffff_ffff);
      wr(8'h3c, 32'hffff_ffff, 4'hf, PS, RESP_OKAY);
      // interrupts and in-band response on a critical uncorrected report
      wr(OFF_IRQ_MASK, 32'h0000_001f, 4'hf, PS, RESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h0000_001f, 4'h1, PS, RESP_OKAY);
      r = mk(ERS_SEV_UE, 8'h02);
      r.critical = 1'b1;
      src.send_rep(r);
      #1;
      chk("inband", 32'h0000_0001, 32'(inband_err));
      chk("crit_irq", 32'h0000_0001, 32'(critical_irq));
      chk("irq", 32'h0000_0001, 32'(irq));
      chk("rec_irq", 32'h0000_0001, 32'(recovery_irq));
      chk("fault_irq", 32'h0000_0000, 32'(fault_irq));
      chkr("st_after", OFF_STATUS, 32'ha000_0002, 32'ha000_00ff);
      chkr("irq_crit", OFF_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
      wr(OFF_IRQ_MASK, 32'h0000_0000, 4'hf, PS, RESP_OKAY);
      chk("irq_masked", 32'h0000_0000, 32'(irq));
      wr(OFF_IRQ_MASK, 32'h0000_001f, 4'hf, PS, RESP_OKAY);
      wr(OFF_IRQ_STAT, 32'h0000_001f, 4'h1, PS, RESP_OKAY);
      chk("irq_clr", 32'h0000_0000, 32'(irq));
      // bridge crossings: inbound, outbound, then an error-free one
      x = '{valid: 1'b1, err: 1'b1, inbound: 1'b1, source: 8'h5a};
      src.send_xfer(x);
      chkr("bridge_in", OFF_BRIDGE, 32'h8001_5a00, 32'hffff_ffff);
      x.inbound = 1'b0;
      x.source = 8'hc3;
      src.send_xfer(x);
      x.err = 1'b0;
      x.source = 8'h11;
      src.send_xfer(x);
      chkr("bridge_out", OFF_BRIDGE, 32'h8000_c300, 32'hffff_ffff);
      chkr("irq_brg", OFF_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
      msi(64'h0000_0000_8000_0100, 1'b0);
      msi(64'h0000_0000_4000_0000, 1'b1);
      test_done();
   end
endmodule
